// ### src/nine_bit_serial_port.sv
// Purpose: nine-bit asynchronous serial port (modes 2 and 3)
// Assumes: sys_clk is the oscillator; all inputs synchronous to it
// Notes: registers reached over classic Wishbone, one wait state
//
// Functional notes
// [R01] frame: low start, eight data bits lsb first, ninth bit, high stop
// [R02] transmitted ninth bit equals the software tx_ninth_bit value
// [R03] mode 2 rate osc/64 or /32, or /32 or /16 in 6-clock
// [R04] mode 3 rate comes from timer 1 or timer 2 overflows
// [R05] buffer write requests transmit and loads tx_ninth_bit into slot 9
// [R06] transmit starts at the next divide-by-16 rollover
// [R07] start bit first, data enabled one bit later, shift one bit later
// [R08] first shift inserts the stop one, later shifts insert zeros
// [R09] final shift ends send and sets tx_done_flag at rollover 11
// [R10] falling edge found at 16x rate resets counter, loads 1FFH
// [R11] each bit is the majority of samples at counter states 7, 8, 9
// [R12] non-zero start bit aborts and resumes edge search
// [R13] nine-bit receive shifter; start at left end triggers final shift
// [R14] load only if rx_done_flag clear and filter off or ninth bit one
// [R15] load puts ninth bit, eight data bits, sets rx_done_flag
// [R16] one bit time after final shift resume edge search
// [R17] interrupt is rx_done_flag OR tx_done_flag; only software clears
// [R18] software set or clear of flags acts like hardware
// [R19] baud_double_bit selects faster rate, clear after reset; the code ignores it when mode 3 takes timer 2 overflows
// [R20] timer 1 mode 3 rate is 2^double/32 (or /16) of overflow rate
// [R21] reception starts only while receive enable is one
// [R22] peer sends address with ninth bit one, data with zero
// [R23] discarded frame leaves buffer and rx_ninth_bit unchanged
`timescale 1ns/1ps
`default_nettype none

module nine_bit_serial_port #(
  parameter int ADDR_W = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire serial9_pkg::wb_req_t wbReq,
  output serial9_pkg::wb_rsp_t wbRsp,
  input wire logic serialIn,
  output logic serialOut,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  output logic serialIrq
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  // the map needs offsets up to 0x8 inside the address field
  generate
    if (ADDR_W != 4)
    begin : g_bad_addr
      $error("ADDR_W must be 4");
    end
  endgenerate

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] presc;
    logic dblPend;
    logic [3:0] txDiv;
    serial9_pkg::tx_state_t txSt;
    logic txReq;
    logic [9:0] tsr;
    logic txd;
    serial9_pkg::rx_state_t rxSt;
    logic [3:0] rxDiv;
    logic [8:0] rsr;
    logic rxFirst;
    logic [1:0] samp;
    logic rxPrev;
    logic [7:0] rxBuf;
    logic [6:0] ctrl;
    logic [2:0] pwr;
    logic ack;
    logic [31:0] dat;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // two of three vote
  function automatic logic vote3(input logic a, input logic b,
                                 input logic c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction

  // receive shifter holds d0 at bit 7, so flip into buffer order
  function automatic logic [7:0] flip8(input logic [7:0] v);
    logic [7:0] f;
    f = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      f[i] = v[7 - i];
    end
    flip8 = f;
  endfunction

  // register select, used by both the read and the write path
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  logic busReq;
  logic wrNow;
  logic baudDouble;
  logic sixClock;
  logic mode3;
  logic [2:0] need;
  logic src;
  logic tick;
  logic txRoll;
  logic rxVote;
  logic rxSet;
  logic txSet;
  logic [31:0] rdMux;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    state_nxt = state_r;
    rxSet = 1'b0;
    txSet = 1'b0;
    busReq = wbReq.cyc & wbReq.stb;
    // writes land on the edge where ack is high
    wrNow = busReq & wbReq.we & state_r.ack & wbReq.sel[0];
    baudDouble = state_r.pwr[serial9_pkg::BAUD_DOUBLE_POS];
    sixClock = state_r.pwr[serial9_pkg::SIX_CLOCK_POS];
    mode3 = state_r.ctrl[serial9_pkg::MODE3_POS];

    // 16x tick: mode 2 counts oscillator cycles
    if (!mode3)
    begin
      src = 1'b1;
      if (sixClock)
        need = baudDouble ? serial9_pkg::M2_DIV_6CLK_FAST
                          : serial9_pkg::M2_DIV_6CLK_SLOW; // R03
      else
        need = baudDouble ? serial9_pkg::M2_DIV_12CLK_FAST
                          : serial9_pkg::M2_DIV_12CLK_SLOW; // R03 R19
    end
    // mode 3 counts timer overflows
    else if (state_r.pwr[serial9_pkg::TIMER2_SEL_POS])
    begin
      src = timer2Ovf; // R04
      need = serial9_pkg::M3_DIV_ONE;
    end
    else
    begin
      src = timer1Ovf; // R04
      need = (!sixClock && !baudDouble) ? serial9_pkg::M3_DIV_T1_SLOW
                                        : serial9_pkg::M3_DIV_ONE; // R20
    end
    tick = state_r.dblPend;
    state_nxt.dblPend = 1'b0;
    if (src)
    begin
      if ({1'b0, state_r.presc} >= need - 3'h1)
      begin
        tick = 1'b1;
        state_nxt.presc = 2'h0;
      end
      else
      begin
        state_nxt.presc = state_r.presc + 2'h1;
      end
    end
    // 6-clock with doubling needs two ticks per overflow
    if (mode3 && !state_r.pwr[serial9_pkg::TIMER2_SEL_POS] &&
        sixClock && baudDouble && timer1Ovf)
    begin
      state_nxt.dblPend = 1'b1; // R20
    end

    // transmit side; counter free-runs so bits align to it
    txRoll = tick && (state_r.txDiv == serial9_pkg::DIV_LAST);
    if (tick)
    begin
      state_nxt.txDiv = state_r.txDiv + 4'h1;
    end
    case (state_r.txSt)
      serial9_pkg::TX_IDLE:
      begin
        state_nxt.txd = 1'b1;
        if (txRoll && state_r.txReq)
        begin
          state_nxt.txSt = serial9_pkg::TX_START; // R06
          state_nxt.txReq = 1'b0;
          state_nxt.txd = 1'b0; // R01 R07
        end
      end
      serial9_pkg::TX_START:
      begin
        if (txRoll)
        begin
          state_nxt.txSt = serial9_pkg::TX_DATA; // R07
          state_nxt.txd = state_r.tsr[0];
        end
      end
      serial9_pkg::TX_DATA:
      begin
        if (txRoll)
        begin
          // first shift places the stop one above the ninth bit
          state_nxt.tsr = {1'b0, 1'b1, state_r.tsr[8:1]}; // R08
          state_nxt.txd = state_r.tsr[1];
          state_nxt.txSt = serial9_pkg::TX_SHIFT;
        end
      end
      serial9_pkg::TX_SHIFT:
      begin
        if (txRoll)
        begin
          state_nxt.tsr = {1'b0, state_r.tsr[9:1]}; // R08
          state_nxt.txd = state_r.tsr[1];
          // ninth bit out, stop beside it, zeros beyond
          if (state_r.tsr[9:1] == 9'h001)
          begin
            state_nxt.txSt = serial9_pkg::TX_IDLE; // R09
            state_nxt.txd = 1'b1;
            txSet = 1'b1;
          end
        end
      end
      default:
      begin
        state_nxt.txSt = serial9_pkg::TX_IDLE;
        state_nxt.txd = 1'b1;
      end
    endcase

    // receive side; input sampled on every 16x tick
    rxVote = vote3(state_r.samp[1], state_r.samp[0], serialIn); // R11
    if (tick)
    begin
      state_nxt.rxPrev = serialIn;
      state_nxt.rxDiv = state_r.rxDiv + 4'h1;
      if (state_r.rxDiv == serial9_pkg::SAMPLE_A)
        state_nxt.samp[1] = serialIn; // R11
      if (state_r.rxDiv == serial9_pkg::SAMPLE_B)
        state_nxt.samp[0] = serialIn; // R11
    end
    case (state_r.rxSt)
      serial9_pkg::RX_HUNT:
      begin
        if (tick && state_r.ctrl[serial9_pkg::RX_EN_POS] &&
            state_r.rxPrev && !serialIn) // R21
        begin
          // restart counter so rollovers match incoming bit edges
          state_nxt.rxDiv = 4'h1; // R10
          state_nxt.rsr = serial9_pkg::RX_SHIFT_LOAD; // R10
          state_nxt.rxFirst = 1'b1;
          state_nxt.rxSt = serial9_pkg::RX_RECV;
        end
      end
      serial9_pkg::RX_RECV:
      begin
        if (tick && state_r.rxDiv == serial9_pkg::SAMPLE_C)
        begin
          if (state_r.rxFirst)
          begin
            state_nxt.rxFirst = 1'b0;
            if (rxVote)
              state_nxt.rxSt = serial9_pkg::RX_HUNT; // R12
            else
              state_nxt.rsr = {state_r.rsr[7:0], 1'b0}; // R12 R13
          end
          else if (!state_r.rsr[8])
          begin
            // final shift: vote is the ninth data bit
            state_nxt.rxSt = serial9_pkg::RX_TAIL; // R13
            if (!state_r.ctrl[serial9_pkg::RX_DONE_POS] &&
                (!state_r.ctrl[serial9_pkg::MPF_EN_POS] || rxVote)) // R14
            begin
              state_nxt.rxBuf = flip8(state_r.rsr[7:0]); // R15 R01
              state_nxt.ctrl[serial9_pkg::RX_NINTH_POS] = rxVote; // R15
              rxSet = 1'b1; // R15
            end
            // else buffer and ninth bit stay as they were R23
          end
          else
          begin
            state_nxt.rsr = {state_r.rsr[7:0], rxVote}; // R13
          end
        end
      end
      serial9_pkg::RX_TAIL:
      begin
        if (tick && state_r.rxDiv == serial9_pkg::SAMPLE_C)
          state_nxt.rxSt = serial9_pkg::RX_HUNT; // R16
      end
      default:
      begin
        state_nxt.rxSt = serial9_pkg::RX_HUNT;
      end
    endcase

    // bus writes; a hardware set in the same cycle wins
    if (wrNow && hit(wbReq.adr, serial9_pkg::SERIAL_CONTROL_OFS))
    begin
      state_nxt.ctrl = wbReq.dat[6:0]; // R18
      if (rxSet)
        state_nxt.ctrl[serial9_pkg::RX_NINTH_POS] = rxVote; // R15
    end
    if (rxSet)
    begin
      state_nxt.ctrl[serial9_pkg::RX_DONE_POS] = 1'b1; // R15 R18
    end
    if (txSet)
    begin
      state_nxt.ctrl[serial9_pkg::TX_DONE_POS] = 1'b1; // R09 R18
    end
    if (wrNow && hit(wbReq.adr, serial9_pkg::SERIAL_BUFFER_OFS))
    begin
      // any write with sel[0] set requests a send and captures the ninth bit now
      state_nxt.tsr = {1'b0, state_r.ctrl[serial9_pkg::TX_NINTH_POS],
                       wbReq.dat[7:0]}; // R02 R05
      state_nxt.txReq = 1'b1; // R05
    end
    if (wrNow && hit(wbReq.adr, serial9_pkg::POWER_CONTROL_OFS))
    begin
      state_nxt.pwr = wbReq.dat[2:0]; // R19
    end

    // read mux; unmapped words read zero
    rdMux = 32'h0000_0000;
    if (hit(wbReq.adr, serial9_pkg::SERIAL_CONTROL_OFS))
      rdMux[6:0] = state_r.ctrl;
    else if (hit(wbReq.adr, serial9_pkg::SERIAL_BUFFER_OFS))
      rdMux[7:0] = state_r.rxBuf;
    else if (hit(wbReq.adr, serial9_pkg::POWER_CONTROL_OFS))
      rdMux[2:0] = state_r.pwr;

    // one wait state, ack lasts one cycle
    state_nxt.ack = busReq & !state_r.ack;
    if (busReq && !state_r.ack)
      state_nxt.dat = rdMux;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // every field takes a constant under reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= '0;
      state_r.txd <= 1'b1;
      state_r.rxPrev <= 1'b1;
      state_r.rsr <= serial9_pkg::RX_SHIFT_LOAD;
      state_r.ctrl <= serial9_pkg::SERIAL_CONTROL_RST;
      state_r.pwr <= serial9_pkg::POWER_CONTROL_RST; // R19
      state_r.txSt <= serial9_pkg::TX_IDLE;
      state_r.rxSt <= serial9_pkg::RX_HUNT;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // flags stay until software clears them
  assign serialIrq = state_r.ctrl[serial9_pkg::RX_DONE_POS] |
                     state_r.ctrl[serial9_pkg::TX_DONE_POS]; // R17
  assign serialOut = state_r.txd; // R01
  assign wbRsp.ack = state_r.ack;
  assign wbRsp.dat = state_r.dat;

endmodule // nine_bit_serial_port

`default_nettype wire

// ### src/serial9_pkg.sv
// Purpose: shared constants and types of the nine-bit serial port
// Assumes: classic Wishbone slave with 32-bit data, one clock
// Notes: offsets are byte addresses of aligned words
package serial9_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] SERIAL_CONTROL_OFS = 4'h0;
  localparam logic [3:0] SERIAL_BUFFER_OFS = 4'h4;
  localparam logic [3:0] POWER_CONTROL_OFS = 4'h8;

  // serial_control_reg field positions
  localparam int RX_DONE_POS = 0;
  localparam int TX_DONE_POS = 1;
  localparam int RX_NINTH_POS = 2;
  localparam int TX_NINTH_POS = 3;
  localparam int RX_EN_POS = 4;
  localparam int MPF_EN_POS = 5;
  localparam int MODE3_POS = 6;

  // power_control_reg field positions
  localparam int BAUD_DOUBLE_POS = 0;
  localparam int SIX_CLOCK_POS = 1;
  localparam int TIMER2_SEL_POS = 2;

  // reset values
  localparam logic [6:0] SERIAL_CONTROL_RST = 7'h00;
  localparam logic [2:0] POWER_CONTROL_RST = 3'h0;
  localparam logic [8:0] RX_SHIFT_LOAD = 9'h1ff;

  // ****************************************************************
  // timing counts, in sys_clk cycles per 16x tick (mode 2)
  // ****************************************************************
  localparam logic [2:0] M2_DIV_12CLK_SLOW = 3'h4;
  localparam logic [2:0] M2_DIV_12CLK_FAST = 3'h2;
  localparam logic [2:0] M2_DIV_6CLK_SLOW = 3'h2;
  localparam logic [2:0] M2_DIV_6CLK_FAST = 3'h1;
  // timer overflows per 16x tick (mode 3, timer 1, 12-clock, slow)
  localparam logic [2:0] M3_DIV_T1_SLOW = 3'h2;
  localparam logic [2:0] M3_DIV_ONE = 3'h1;

  // bit detector sample points (7th, 8th, 9th counter states)
  localparam logic [3:0] SAMPLE_A = 4'h6;
  localparam logic [3:0] SAMPLE_B = 4'h7;
  localparam logic [3:0] SAMPLE_C = 4'h8;
  localparam logic [3:0] DIV_LAST = 4'hf;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_SHIFT = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_RECV = 2'b01,
    RX_TAIL = 2'b11
  } rx_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

endpackage

// ### testbench/serial_port_monitor.sv
// Purpose: port checker of the nine-bit serial port
// Assumes: one clock, nrst async active low
// Notes: bound to the top module ports
`timescale 1ns/1ps
`default_nettype none

module serial_port_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire serial9_pkg::wb_req_t wbReq,
  input wire serial9_pkg::wb_rsp_t wbRsp,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  input wire logic serialIrq
);
  // ****************************************************************
  // helper terms
  // ****************************************************************
  logic ctlWr;
  logic ctlRd;
  // control access acknowledged at this edge; a write lands just after
  assign ctlWr = wbRsp.ack && wbReq.we && wbReq.sel[0] && wbReq.adr == 4'h0;
  assign ctlRd = wbRsp.ack && !wbReq.we && wbReq.adr == 4'h0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_ack_follows: assert property (
    wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
    else $error("ack late");
  a_ack_single: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack too long");
  a_line_idle: assert property (!$past(nrst) |-> serialOut)
    else $error("line not idle after reset");
  a_bit_min: assert property (
    $fell(serialOut) |-> (!serialOut)[*8])
    else $error("low bit too short");
  a_irq_reset: assert property (!$past(nrst) |-> !serialIrq)
    else $error("irq after reset");
  a_irq_holds: assert property (
    serialIrq && !ctlWr |=> serialIrq)
    else $error("irq cleared by hardware");
  a_irq_sw_set: assert property (
    ctlWr && wbReq.dat[1:0] != 2'b00 |=> serialIrq)
    else $error("software set ignored");
  a_irq_sw_clr: assert property (
    ctlWr && wbReq.dat[1:0] == 2'b00 |=> !serialIrq)
    else $error("software clear ignored");
  a_irq_flags: assert property (
    ctlRd |-> (|wbRsp.dat[1:0]) == serialIrq ||
      (|wbRsp.dat[1:0]) == $past(serialIrq))
    else $error("irq differs from flags");
endmodule // serial_port_monitor

`default_nettype wire

// ### testbench/remote_node.sv
// Purpose: remote nine-bit serial node
// Assumes: bit length given in sys_clk cycles
// Notes: sends on demand, catches every frame it sees
`timescale 1ns/1ps
`default_nettype none

module remote_node (
  input wire logic sys_clk,
  input wire logic [7:0] bitLen,
  input wire logic lineIn,
  output logic lineOut
);
  logic [10:0] capWord;
  int capCount;

  initial
  begin
    lineOut = 1'b1;
    capCount = 0;
    capWord = '0;
  end

  // drives nb bits lsb first, then lets the line idle high
  task automatic send(input logic [10:0] frame, input int nb,
    input int len);
    for (int i = 0; i < nb; i++)
    begin
      lineOut <= frame[i];
      repeat (len) @(posedge sys_clk);
    end
    lineOut <= 1'b1;
  endtask

  // mid-bit sampling; a wrong rate shows up as corrupted bits
  always
  begin
    @(negedge lineIn);
    repeat (bitLen / 2) @(posedge sys_clk);
    for (int i = 0; i < 11; i++)
    begin
      capWord[i] = lineIn;
      if (i < 10)
        repeat (bitLen) @(posedge sys_clk);
    end
    capCount++;
  end
endmodule // remote_node

`default_nettype wire

// ### testbench/tb_nine_bit_async_serial_port.sv
// Purpose: self-checking bench of the nine-bit serial port
// Assumes: timer overflows every other cycle
// Notes: each rate setting gets a transmit and a receive
`timescale 1ns/1ps
`default_nettype none

module tb_nine_bit_async_serial_port;
  localparam logic [3:0] CTL = serial9_pkg::SERIAL_CONTROL_OFS;
  localparam logic [3:0] BUF = serial9_pkg::SERIAL_BUFFER_OFS;
  localparam logic [3:0] PWR = serial9_pkg::POWER_CONTROL_OFS;
  localparam logic [2:0] PWRS [7] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h4, 3'h3,
    3'h3};
  localparam logic M3S [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  localparam logic [7:0] LENS [7] = '{8'd64, 8'd32, 8'd32, 8'd64, 8'd32,
    8'd16, 8'd16};
  logic sys_clk;
  logic nrst;
  serial9_pkg::wb_req_t wbReq;
  serial9_pkg::wb_rsp_t wbRsp;
  logic serialIn;
  logic serialOut;
  logic timer1Ovf;
  logic timer2Ovf;
  logic serialIrq;
  logic [7:0] bitLen;
  int nFail;
  int totalChecks;

  nine_bit_serial_port #(.ADDR_W(4)) nine_bit_serial_port_inst (
    .sys_clk, .nrst, .wbReq, .wbRsp, .serialIn, .serialOut,
    .timer1Ovf, .timer2Ovf, .serialIrq);
  remote_node remote_node_inst (.sys_clk, .bitLen,
    .lineIn(serialOut), .lineOut(serialIn));

  // ****************************************************************
  // clock and timer overflow pulses
  // ****************************************************************
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    timer1Ovf <= ~timer1Ovf;
    timer2Ovf <= ~timer2Ovf;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic wrap_up();
    if (nFail == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // classic cycle: request held until ack is sampled high
  task automatic xfer(input logic we, input logic [3:0] a,
    input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    wbReq <= '{1'b1, 1'b1, we, a, 4'hf, {24'h00_0000, d}};
    @(posedge sys_clk);
    while (wbRsp.ack !== 1'b1)
      @(posedge sys_clk);
    q = wbRsp.dat;
    wbReq <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input string nm, input logic [3:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, q, e);
  endtask

  // one frame in, then irq and buffer compared
  task automatic rxTry(input logic [8:0] v, input logic [7:0] eb,
    input logic ei);
    remote_node_inst.send({1'b1, v, 1'b0}, 11, bitLen);
    repeat (bitLen) @(posedge sys_clk);
    chk("irq", serialIrq, ei);
    rdChk("buffer", BUF, eb);
  endtask

  // ****************************************************************
  // watchdog and main sequence
  // ****************************************************************
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    nFail++;
    wrap_up();
  end

  initial
  begin : main
    logic [7:0] d;
    logic [7:0] cfg;
    int c0;
    sys_clk = 1'b0;
    nrst = 1'b0;
    wbReq = '0;
    timer1Ovf = 1'b0;
    timer2Ovf = 1'b0;
    bitLen = 8'd64;
    nFail = 0;
    totalChecks = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    chk("irq", serialIrq, 1'b0);
    rdChk("ctrl", CTL, 32'h0000_0000);
    rdChk("power", PWR, 32'h0000_0000);
    rdChk("unmapped", 4'hc, 32'h0000_0000);
    // every rate source and mode 2 divider setting; timer 1 only without doubling or with both
    for (int i = 0; i < 7; i++)
    begin
      d = 8'h5a ^ {i[3:0], i[3:0]};
      cfg = {1'b0, M3S[i], 2'b01, i[0], 3'b000};
      bitLen <= LENS[i];
      wr(PWR, {5'h00, PWRS[i]});
      wr(CTL, cfg);
      c0 = remote_node_inst.capCount;
      wr(BUF, d);
      for (int k = 0; k < 4000 && remote_node_inst.capCount == c0; k++)
        @(posedge sys_clk);
      chk("frame", remote_node_inst.capWord, {1'b1, i[0], d, 1'b0});
      repeat (LENS[i]) @(posedge sys_clk);
      rdChk("txdone", CTL, {24'h00_0000, cfg | 8'h02});
      wr(CTL, cfg);
      rxTry({~i[0], ~d}, ~d, 1'b1);
      rdChk("rxdone", CTL, {24'h00_0000, cfg | {5'h00, ~i[0], 2'b01}});
      wr(CTL, cfg);
    end
    wr(PWR, 8'h00);
    bitLen <= 8'd64;
    wr(CTL, 8'h30);
    rxTry(9'h011, ~d, 1'b0);
    rxTry(9'h122, 8'h22, 1'b1);
    rxTry(9'h033, 8'h22, 1'b1);
    rdChk("ctrl", CTL, 32'h0000_0035);
    wr(CTL, 8'h00);
    rxTry(9'h144, 8'h22, 1'b0);
    wr(CTL, 8'h10);
    remote_node_inst.send(11'h000, 1, 4);
    repeat (128) @(posedge sys_clk);
    chk("glitch", serialIrq, 1'b0);
    rxTry(9'h155, 8'h55, 1'b1);
    wr(CTL, 8'h02);
    @(posedge sys_clk);
    chk("swset", serialIrq, 1'b1);
    wrap_up();
  end
endmodule // tb_nine_bit_async_serial_port

bind nine_bit_serial_port serial_port_monitor serial_port_monitor_inst (
  .sys_clk, .nrst, .wbReq, .wbRsp, .serialIn, .serialOut, .timer1Ovf,
  .timer2Ovf, .serialIrq);

`default_nettype wire
